// file: verilog/ppfs_pkg.sv
// constants, layouts and routing tables for the port pin function selector
// Function
// RULE1 - select code zero leaves pin high impedance
// RULE2 - interrupt select bit drives assigned interrupt input
// RULE3 - port 9 analog bit connects converter input
// RULE4 - port 9 pin 0 feeds converter channel 108
// RULE5 - P8.3: timer 4C at 01, DMA ack at 18
// RULE6 - P8.3: ch10 clock, ch010 clock, ch010 flow
// RULE7 - P8.6: ch10 receive, ch010 receive
// RULE8 - P8.7: SD data2 alt, ch010 transmit
// RULE9 - PA1: ch12 clock, SPI select2, card detect
// RULE10 - PA2: ch12 receive, SD write protect
// RULE11 - PA4: ch12 transmit at code 0c
// RULE12 - PA6: ch12 flow select, SPI master out
// RULE13 - port A pins map to fixed interrupt inputs
// RULE14 - PB0/PB1: ch4 and ch6 receive/transmit
// RULE15 - PB4: ch9, ch11, ch011 flow, driver enable
// RULE16 - PB5-7: ch011 and ch11 clock/receive/transmit
// RULE17 - PB3: timer 0A, 4A, 8-bit out, OUTPUT_DISABLE_INPUT_11
// RULE18 - unassigned codes route nothing to pin
// RULE19 - registers read/write, reset to all zero
package ppfs_pkg;

  localparam int NPIN = 23;
  localparam int NSLOT = 6;
  localparam int NIRQ = 16;

  // pin indices, also the register word index (byte address = 4 * index)
  localparam int P83 = 0;
  localparam int P86 = 1;
  localparam int P87 = 2;
  localparam int P90 = 3;
  localparam int PA0 = 7;
  localparam int PB0 = 15;
  localparam int P9_COUNT = 4;

  localparam int ADDR_W = 5;
  localparam logic [ADDR_W-1:0] LAST_ADDR = 5'h16;

  localparam logic [5:0] CODE_HIZ = 6'h00;
  localparam logic [7:0] CFG_RESET = 8'h00;

  // register layout: bit 7 analog select, bit 6 interrupt select, 5:0 function select
  typedef struct packed {
    logic analog_input_select;
    logic interrupt_input_select;
    logic [5:0] psel;
  } ppfs_cfg_s;

  typedef struct packed {
    logic [NSLOT-1:0] out;
    logic [NSLOT-1:0] oe;
  } ppfs_fn_drive_s;

  typedef logic [5:0] ppfs_code_t;

  // per pin, the code that selects each peripheral slot; CODE_HIZ marks an empty slot
  localparam ppfs_code_t FS_CODE [NPIN][NSLOT] = '{
    '{6'h01, 6'h0a, 6'h0b, 6'h18, 6'h2c, 6'h2d}, // P83
    '{6'h03, 6'h08, 6'h0a, 6'h2c, 6'h00, 6'h00}, // P86
    '{6'h03, 6'h08, 6'h0a, 6'h1a, 6'h2c, 6'h00}, // P87
    '{6'h00, 6'h00, 6'h00, 6'h00, 6'h00, 6'h00}, // P90
    '{6'h00, 6'h00, 6'h00, 6'h00, 6'h00, 6'h00}, // P91
    '{6'h00, 6'h00, 6'h00, 6'h00, 6'h00, 6'h00}, // P92
    '{6'h00, 6'h00, 6'h00, 6'h00, 6'h00, 6'h00}, // P93
    '{6'h01, 6'h03, 6'h06, 6'h07, 6'h08, 6'h0e}, // PA0
    '{6'h01, 6'h0a, 6'h0c, 6'h0e, 6'h31, 6'h00}, // PA1
    '{6'h08, 6'h0a, 6'h0c, 6'h0e, 6'h31, 6'h00}, // PA2
    '{6'h01, 6'h02, 6'h03, 6'h04, 6'h06, 6'h0a}, // PA3
    '{6'h01, 6'h05, 6'h0a, 6'h0c, 6'h0d, 6'h0e}, // PA4
    '{6'h03, 6'h06, 6'h08, 6'h0d, 6'h0e, 6'h00}, // PA5
    '{6'h07, 6'h0b, 6'h0c, 6'h0d, 6'h0e, 6'h00}, // PA6
    '{6'h03, 6'h06, 6'h0d, 6'h0e, 6'h00, 6'h00}, // PA7
    '{6'h01, 6'h03, 6'h06, 6'h0a, 6'h0b, 6'h00}, // PB0
    '{6'h01, 6'h02, 6'h05, 6'h0a, 6'h0b, 6'h00}, // PB1
    '{6'h03, 6'h04, 6'h06, 6'h0a, 6'h0b, 6'h00}, // PB2
    '{6'h01, 6'h02, 6'h05, 6'h07, 6'h0a, 6'h0b}, // PB3
    '{6'h03, 6'h06, 6'h0b, 6'h24, 6'h2c, 6'h2e}, // PB4
    '{6'h01, 6'h05, 6'h0a, 6'h24, 6'h2c, 6'h00}, // PB5
    '{6'h01, 6'h03, 6'h0a, 6'h24, 6'h2c, 6'h00}, // PB6
    '{6'h01, 6'h03, 6'h0a, 6'h24, 6'h2c, 6'h00}  // PB7
  };

  // interrupt routing: valid flag, input number, deep-standby flag
  localparam logic [NPIN-1:0] IRQ_HAS = 23'h7fff80;
  localparam logic [NPIN-1:0] IRQ_DS = 23'h010c00;
  localparam logic [3:0] IRQ_NUM [NPIN] = '{
    4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0,
    4'h0, 4'hb, 4'ha, 4'h6, 4'h5, 4'h5, 4'he, 4'h7,
    4'hc, 4'h4, 4'h2, 4'h3, 4'h4, 4'hd, 4'h6, 4'hf
  };

endpackage : ppfs_pkg

// file: verilog/ppfs_top.sv
// port pin function selector: registers, per-pin routing, interrupt and analog select
`timescale 1ns/1ps
module ppfs_top
  import ppfs_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // avalon-mm register slave
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // pads
  input wire logic [NPIN-1:0] pad_in,
  output logic [NPIN-1:0] pad_out,
  output logic [NPIN-1:0] pad_oe,
  // peripheral side, per pin and slot
  input wire ppfs_fn_drive_s fn_drive [NPIN],
  output logic [NSLOT-1:0] fn_sel [NPIN],
  output logic [NSLOT-1:0] fn_in [NPIN],
  // interrupt inputs and analog connections
  output logic [NIRQ-1:0] irq_req,
  output logic [NIRQ-1:0] irq_ds_req,
  output logic [P9_COUNT-1:0] analog_connect,
  output logic analog_channel_108
);

  // ==========================================================
  // register bus
  ppfs_cfg_s cfg_r [NPIN];
  logic ack_r;
  logic bus_req;
  logic addr_ok;
  logic [31:0] rdata_nxt;

  assign bus_req = avs_read | avs_write;
  assign addr_ok = avs_address <= LAST_ADDR;
  // one wait state: the answer comes at the second edge of every access
  assign avs_waitrequest = bus_req & ~ack_r;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= bus_req & ~ack_r;
    end
  end

  always_comb begin
    rdata_nxt = 32'h0000_0000;
    if (addr_ok) begin
      rdata_nxt = {24'h00_0000, cfg_r[avs_address]}; // [RULE19]
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && !ack_r) begin
      avs_readdata <= rdata_nxt;
    end
  end

  // ==========================================================
  // pin configuration registers
  genvar gp;
  generate
    for (gp = 0; gp < NPIN; gp++) begin : g_cfg
      always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          cfg_r[gp] <= CFG_RESET; // [RULE19]
        end else if (avs_write && ack_r && avs_byteenable[0] && avs_address == gp) begin
          cfg_r[gp] <= avs_writedata[7:0]; // [RULE19]
        end
      end
    end
  endgenerate

  // ==========================================================
  // pad input synchroniser; only the second stage is looked at
  logic [NPIN-1:0] pad_s1_r;
  logic [NPIN-1:0] pad_s2_r;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pad_s1_r <= '0;
      pad_s2_r <= '0;
    end else begin
      pad_s1_r <= pad_in;
      pad_s2_r <= pad_s1_r;
    end
  end

  // ==========================================================
  // per-pin function decode and pad drive
  logic [NSLOT-1:0] sel_nxt [NPIN];
  logic [NPIN-1:0] analog_on;

  generate
    for (gp = 0; gp < NPIN; gp++) begin : g_pin
      // analog use only exists on port 9
      if (gp >= P90 && gp < P90 + P9_COUNT) begin : g_an
        assign analog_on[gp] = cfg_r[gp].analog_input_select; // [RULE3]
      end else begin : g_noan
        assign analog_on[gp] = 1'b0;
      end

      // code zero and unassigned codes hit no slot, so the pad stays undriven
      always_comb begin
        for (int s = 0; s < NSLOT; s++) begin
          sel_nxt[gp][s] = (FS_CODE[gp][s] != CODE_HIZ) &&
                           (cfg_r[gp].psel == FS_CODE[gp][s]) &&
                           !analog_on[gp]; // [RULE1] [RULE18] [RULE5] [RULE6] [RULE7] [RULE8]
        end
      end

      always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          fn_sel[gp] <= '0;
          fn_in[gp] <= '0;
          pad_out[gp] <= 1'b0;
          pad_oe[gp] <= 1'b0;
        end else begin
          fn_sel[gp] <= sel_nxt[gp]; // [RULE9] [RULE10] [RULE11] [RULE12] [RULE14]
          fn_in[gp] <= sel_nxt[gp] & {NSLOT{pad_s2_r[gp]}}; // [RULE15] [RULE16] [RULE17]
          pad_out[gp] <= |(sel_nxt[gp] & fn_drive[gp].out);
          pad_oe[gp] <= |(sel_nxt[gp] & fn_drive[gp].oe); // [RULE1]
        end
      end
    end
  endgenerate

  // ==========================================================
  // interrupt input routing
  logic [NIRQ-1:0] irq_nxt;
  logic [NIRQ-1:0] irq_ds_nxt;

  always_comb begin
    irq_nxt = '0;
    irq_ds_nxt = '0;
    for (int p = 0; p < NPIN; p++) begin
      if (IRQ_HAS[p] && cfg_r[p].interrupt_input_select) begin // [RULE2]
        if (IRQ_DS[p]) begin
          irq_ds_nxt[IRQ_NUM[p]] = irq_ds_nxt[IRQ_NUM[p]] | pad_s2_r[p]; // [RULE13]
        end else begin
          irq_nxt[IRQ_NUM[p]] = irq_nxt[IRQ_NUM[p]] | pad_s2_r[p]; // [RULE13]
        end
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      irq_req <= '0;
      irq_ds_req <= '0;
    end else begin
      irq_req <= irq_nxt;
      irq_ds_req <= irq_ds_nxt;
    end
  end

  // ==========================================================
  // analog converter connections
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      analog_connect <= '0;
      analog_channel_108 <= 1'b0;
    end else begin
      analog_connect <= analog_on[P90 +: P9_COUNT]; // [RULE3]
      analog_channel_108 <= analog_on[P90]; // [RULE4]
    end
  end

  // ==========================================================
  // assertions
  a_wait_first: assert property (@(posedge mclk) disable iff (!rst_n)
    (bus_req && !ack_r) |-> avs_waitrequest) // [RULE19]
    else $error("first access cycle not stalled");

  a_wait_release: assert property (@(posedge mclk) disable iff (!rst_n)
    avs_waitrequest |=> !avs_waitrequest) // [RULE19]
    else $error("waitrequest held past one cycle");

  a_write_read_back: assert property (@(posedge mclk) disable iff (!rst_n)
    (avs_write && ack_r && avs_byteenable[0] && avs_address == 5'h00)
      |=> cfg_r[P83] == $past(avs_writedata[7:0])) // [RULE19]
    else $error("write did not store");

  a_hiz_zero: assert property (@(posedge mclk) disable iff (!rst_n)
    (cfg_r[P83].psel == CODE_HIZ) |=> (!pad_oe[P83] && fn_sel[P83] == '0)) // [RULE1]
    else $error("zero code drove pad");

  a_dma_ack_slot: assert property (@(posedge mclk) disable iff (!rst_n)
    (cfg_r[P83].psel == FS_CODE[P83][3]) |=> fn_sel[P83] == 6'h08) // [RULE5]
    else $error("dma ack slot not selected");

  a_sel_onehot: assert property (@(posedge mclk) disable iff (!rst_n)
    $onehot0(fn_sel[PB0 + 4])) // [RULE18]
    else $error("more than one function selected");

  a_reserved_code: assert property (@(posedge mclk) disable iff (!rst_n)
    (cfg_r[PA0 + 6].psel == 6'h3f) |=> fn_sel[PA0 + 6] == '0) // [RULE18]
    else $error("reserved code routed a function");

  a_irq_pa7: assert property (@(posedge mclk) disable iff (!rst_n)
    (cfg_r[PA0 + 7].interrupt_input_select && pad_s2_r[PA0 + 7]) |=> irq_req[7]) // [RULE13]
    else $error("pa7 interrupt not routed");

  a_irq_gate: assert property (@(posedge mclk) disable iff (!rst_n)
    !cfg_r[PA0 + 1].interrupt_input_select |=> !irq_req[11]) // [RULE2]
    else $error("interrupt seen without select");

  a_adc_108: assert property (@(posedge mclk) disable iff (!rst_n)
    cfg_r[P90].analog_input_select |=> (analog_channel_108 && !pad_oe[P90])) // [RULE4]
    else $error("channel 108 not connected");

  c_write_cycle: cover property (@(posedge mclk) disable iff (!rst_n)
    avs_write ##1 (avs_write && !avs_waitrequest));
  c_read_cycle: cover property (@(posedge mclk) disable iff (!rst_n)
    avs_read ##1 (avs_read && !avs_waitrequest));
  c_pad_driven: cover property (@(posedge mclk) disable iff (!rst_n) pad_oe[PB0 + 3]);
  c_ds_irq: cover property (@(posedge mclk) disable iff (!rst_n) irq_ds_req[5]);

endmodule : ppfs_top

// file: tb/ppfs_periph_model.sv
// far-side model: peripheral slot drivers and external pad levels
`timescale 1ns/1ps
module ppfs_periph_model
  import ppfs_pkg::*;
(
  // pad level chosen by the bench
  input wire logic pad_lvl,
  // peripheral drive and pad inputs of the selector
  output ppfs_fn_drive_s fn_drive [NPIN],
  output logic [NPIN-1:0] pad_in
);
  // ==========================================================
  // drivers
  // alternating levels per slot, so a wrong slot shows on the pad
  always_comb begin
    for (int p = 0; p < NPIN; p++) begin
      fn_drive[p].out = 6'h15;
      fn_drive[p].oe = 6'h3f;
    end
  end
  assign pad_in = {NPIN{pad_lvl}};
endmodule : ppfs_periph_model

// file: tb/ppfs_top_tb_top.sv
// self-checking testbench for the port pin function selector
`timescale 1ns/1ps
module ppfs_top_tb_top
  import ppfs_pkg::*;
;
  logic mclk = 1'h0;
  logic rst_n = 1'h0;
  logic [ADDR_W-1:0] avs_address = 5'h00;
  logic avs_read = 1'h0;
  logic avs_write = 1'h0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic pad_lvl = 1'h1;
  logic [NPIN-1:0] pad_in, pad_out, pad_oe;
  ppfs_fn_drive_s fn_drive [NPIN];
  logic [NSLOT-1:0] fn_sel [NPIN];
  logic [NSLOT-1:0] fn_in [NPIN];
  logic [NIRQ-1:0] irq_req, irq_ds_req;
  logic [P9_COUNT-1:0] analog_connect;
  logic analog_channel_108;
  int miscompares = 0;
  int compares = 0;
  logic [7:0] rd;
  logic [7:0] pin;
  logic [2:0] s;
  // pin, code, slot
  localparam logic [23:0] SEL [33] = '{
    24'h000100, 24'h001803, 24'h000a01, 24'h002c04, 24'h002d05, 24'h010a02, 24'h012c03,
    24'h021a03, 24'h022c04, 24'h080c02, 24'h080e03, 24'h083104, 24'h090c02, 24'h093104,
    24'h0b0c03, 24'h0d0c02, 24'h0d0e04, 24'h0f0a03, 24'h0f0b04, 24'h100a03, 24'h100b04,
    24'h120100, 24'h120201, 24'h120502, 24'h120703, 24'h130b02, 24'h132403, 24'h132c04,
    24'h132e05, 24'h142c04, 24'h152c04, 24'h162c04, 24'h162403};
  // bit 4 marks the deep-standby output
  localparam logic [7:0] IRQ_EXP [8] = '{
    8'h00, 8'h0b, 8'h0a, 8'h16, 8'h15, 8'h05, 8'h0e, 8'h07};

  always #10 mclk = ~mclk;

  ppfs_top dut (.mclk, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .pad_in, .pad_out, .pad_oe,
    .fn_drive, .fn_sel, .fn_in, .irq_req, .irq_ds_req, .analog_connect, .analog_channel_108);
  ppfs_periph_model far_side (.pad_lvl, .fn_drive, .pad_in);

  // ==========================================================
  // tasks
  task automatic report_and_stop();
    if (miscompares == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // one avalon access; ends on the completion edge
  task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d,
      input logic [3:0] be);
    int n;
    n = 0;
    @(posedge mclk);
    avs_address <= a[4:0];
    avs_writedata <= {24'h0, d};
    avs_byteenable <= be;
    avs_write <= wr;
    avs_read <= ~wr;
    @(negedge mclk);
    while (avs_waitrequest !== 1'h0 && n < 20) begin
      @(negedge mclk);
      n++;
    end
    if (n >= 20) begin
      miscompares++;
      report_and_stop();
    end
    @(posedge mclk);
    rd = avs_readdata[7:0];
    avs_write <= 1'h0;
    avs_read <= 1'h0;
  endtask : bus

  // ==========================================================
  // sequence
  initial begin
    repeat (10) @(posedge mclk);
    rst_n <= 1'h1;
    for (int p = 0; p < NPIN; p++) begin
      bus(1'h0, 8'(p), 8'h00, 4'h0);
      chk("reset value", 32'(rd), 32'h0);
    end
    chk("reset pad enable", 32'(pad_oe), 32'h0);
    bus(1'h1, 8'h0d, 8'h8c, 4'h1);
    bus(1'h1, 8'h0d, 8'h33, 4'h0);
    bus(1'h0, 8'h0d, 8'h00, 4'h0);
    chk("read back", 32'(rd), 32'h8c);
    bus(1'h1, 8'h1c, 8'h55, 4'h1);
    bus(1'h0, 8'h1c, 8'h00, 4'h0);
    chk("unmapped read", 32'(rd), 32'h0);
    for (int i = 0; i < 33; i++) begin
      pin = SEL[i][23:16];
      s = SEL[i][2:0];
      bus(1'h1, pin, {2'h0, SEL[i][13:8]}, 4'h1);
      repeat (2) @(negedge mclk);
      chk("slot select", 32'(fn_sel[pin]), 32'h1 << s);
      chk("slot input", 32'(fn_in[pin]), 32'h1 << s);
      chk("pad drive", 32'({pad_oe[pin], pad_out[pin]}), {30'h0, 1'h1, ~s[0]});
    end
    bus(1'h1, 8'h00, 8'h02, 4'h1);
    bus(1'h1, 8'h03, 8'h01, 4'h1);
    bus(1'h1, 8'h0d, 8'h3f, 4'h1);
    repeat (2) @(negedge mclk);
    chk("reserved code", 32'({fn_sel[0], fn_sel[3], fn_sel[13], pad_oe[3], pad_oe[0]}), 32'h0);
    bus(1'h1, 8'h12, 8'h00, 4'h1);
    repeat (2) @(negedge mclk);
    chk("zero code", 32'({fn_sel[18], pad_oe[18]}), 32'h0);
    for (int i = 0; i < 8; i++) begin
      bus(1'h1, 8'(PA0 + i), 8'h40, 4'h1);
      repeat (2) @(negedge mclk);
      chk("irq set", {irq_ds_req, irq_req}, 32'h1 << IRQ_EXP[i][4:0]);
      bus(1'h1, 8'(PA0 + i), 8'h00, 4'h1);
      repeat (2) @(negedge mclk);
      chk("irq clear", {irq_ds_req, irq_req}, 32'h0);
    end
    bus(1'h1, 8'h08, 8'h40, 4'h1);
    pad_lvl <= 1'h0;
    repeat (4) @(negedge mclk);
    chk("irq pad low", {irq_ds_req, irq_req}, 32'h0);
    bus(1'h1, 8'h03, 8'h80, 4'h1);
    bus(1'h1, 8'h06, 8'h80, 4'h1);
    repeat (2) @(negedge mclk);
    chk("analog", 32'({analog_channel_108, analog_connect}), 32'h19);
    chk("analog pad off", 32'(pad_oe[6:3]), 32'h0);
    bus(1'h1, 8'h03, 8'h00, 4'h1);
    repeat (2) @(negedge mclk);
    chk("analog off", 32'({analog_channel_108, analog_connect}), 32'h08);
    report_and_stop();
  end
endmodule : ppfs_top_tb_top
